/* File: rtl/host_port_arbiter_map.vh */
// constants for the host port arbiter: timing, address limits, reset values
// assumes a 100 MHz system clock and byte strobes from two serial receivers
`ifndef HOST_PORT_ARBITER_MAP_VH
`define HOST_PORT_ARBITER_MAP_VH

// ==========================================
// timing
`define IDLE_TIME_MIN 64'd5
`define CLK_HZ 64'd100000000
// five minutes of sys_clk_in cycles at 100 MHz, sized to the idle counter
`define IDLE_CYCLES 36'd30000000000
`define IDLE_CNT_W 36

// ==========================================
// bus address limits and reset values
`define BUS_ADDR_MIN 5'h01
`define BUS_ADDR_MAX 5'h1e
`define BUS_ADDR_RST 5'h01
`define AUTO_NET_RST 1'b1

// ==========================================
// port selection codes
`define SEL_SERIAL 2'h1
`define SEL_MODULE 2'h2

`endif

/* File: rtl/host_port_arbiter.v */
// arbiter between the native serial port and the optional module serial port
// assumes byte strobes and address settings arrive from outside this clock domain
`timescale 1ns/100ps
`default_nettype none
`include "host_port_arbiter_map.vh"

module host_port_arbiter #(
	parameter [35:0] IDLE_LIMIT = `IDLE_CYCLES
) (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire serial_valid_in,
	input wire [7:0] serial_data_in,
	input wire module_valid_in,
	input wire [7:0] module_data_in,
	input wire addr_load_in,
	input wire [4:0] addr_value_in,
	input wire auto_net_load_in,
	input wire auto_net_value_in,
	output reg cmd_valid_out,
	output reg [7:0] cmd_data_out,
	output reg [1:0] active_port_out,
	output reg [4:0] bus_addr_out,
	output reg auto_net_out,
	output reg manual_net_out
);

	// ==========================================
	// strobe synchronisers and rising-edge detectors
	// only the second and third stages are read, so a metastable first stage never fans out
	wire [1:0] vld_raw = {module_valid_in, serial_valid_in};
	wire [1:0] ld_raw = {auto_net_load_in, addr_load_in};
	wire [1:0] byte_stb;
	wire [1:0] load_stb;
	genvar i;

	generate
		for (i = 0; i < 2; i = i + 1) begin : g_edge
			reg vld_meta_r;
			reg vld_r;
			reg vld_d_r;
			reg ld_meta_r;
			reg ld_r;
			reg ld_d_r;

			always @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					vld_meta_r <= 1'b0;
					vld_r <= 1'b0;
					vld_d_r <= 1'b0;
					ld_meta_r <= 1'b0;
					ld_r <= 1'b0;
					ld_d_r <= 1'b0;
				end else begin
					vld_meta_r <= vld_raw[i];
					vld_r <= vld_meta_r;
					vld_d_r <= vld_r;
					ld_meta_r <= ld_raw[i];
					ld_r <= ld_meta_r;
					ld_d_r <= ld_r;
				end
			end

			// one pulse per rising edge of a strobe; a held-high strobe counts once
			assign byte_stb[i] = vld_r & ~vld_d_r;
			assign load_stb[i] = ld_r & ~ld_d_r;
		end
	endgenerate

	// ==========================================
	// data synchronisers; senders hold data still around their strobes
	// data needs no reset: it is only read under a strobe pulse
	reg [7:0] s_dat_meta_r;
	reg [7:0] s_dat_r;
	reg [7:0] m_dat_meta_r;
	reg [7:0] m_dat_r;
	reg [4:0] a_meta_r;
	reg [4:0] a_r;
	reg n_meta_r;
	reg n_r;

	always @(posedge sys_clk_in) begin
		s_dat_meta_r <= serial_data_in;
		s_dat_r <= s_dat_meta_r;
		m_dat_meta_r <= module_data_in;
		m_dat_r <= m_dat_meta_r;
		a_meta_r <= addr_value_in;
		a_r <= a_meta_r;
		n_meta_r <= auto_net_value_in;
		n_r <= n_meta_r;
	end

	// ==========================================
	// arbitration state
	localparam [2:0] ST_FREE = 3'b001;
	localparam [2:0] ST_SERIAL = 3'b010;
	localparam [2:0] ST_MODULE = 3'b100;

	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [35:0] idle_cnt_r;
	wire idle_done = (idle_cnt_r >= IDLE_LIMIT - 36'h1);
	wire active_byte = (state_r == ST_SERIAL) ? byte_stb[0] :
		(state_r == ST_MODULE) ? byte_stb[1] : 1'b0;

	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_FREE: begin
				// a tie on the same edge goes to the native port
				if (byte_stb[0]) begin
					state_nxt = ST_SERIAL;
				end else if (byte_stb[1]) begin
					state_nxt = ST_MODULE;
				end
			end
			ST_SERIAL, ST_MODULE: begin
				if (!active_byte && idle_done) begin
					state_nxt = ST_FREE;
				end
			end
			default: begin
				state_nxt = ST_FREE;
			end
		endcase
	end

	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state_r <= ST_FREE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// the counter saturates, so a long quiet spell never wraps back to busy
	// bytes on the locked port never reach active_byte, so they cannot restart it
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			idle_cnt_r <= 36'h0;
		end else if (state_r == ST_FREE || active_byte) begin
			idle_cnt_r <= 36'h0;
		end else if (!idle_done) begin
			idle_cnt_r <= idle_cnt_r + 36'h1;
		end
	end

	// ==========================================
	// routing to the command logic; the locked port's bytes are dropped
	// the claiming byte itself is passed on, not swallowed
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cmd_valid_out <= 1'b0;
			cmd_data_out <= 8'h00;
		end else begin
			cmd_valid_out <= 1'b0;
			if (state_nxt == ST_SERIAL && byte_stb[0]) begin
				cmd_valid_out <= 1'b1;
				cmd_data_out <= s_dat_r;
			end else if (state_nxt == ST_MODULE && byte_stb[1]) begin
				cmd_valid_out <= 1'b1;
				cmd_data_out <= m_dat_r;
			end
		end
	end

	// follows the next state so the port shows up with the claiming byte
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			active_port_out <= 2'h0;
		end else begin
			case (state_nxt)
				ST_SERIAL: begin
					active_port_out <= `SEL_SERIAL;
				end
				ST_MODULE: begin
					active_port_out <= `SEL_MODULE;
				end
				default: begin
					active_port_out <= 2'h0;
				end
			endcase
		end
	end

	// ==========================================
	// bus address; out-of-range loads are refused, not clipped
	// refusing keeps address zero, the controller's own, out of reach
	wire addr_ok = (a_r >= `BUS_ADDR_MIN) && (a_r <= `BUS_ADDR_MAX);

	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			bus_addr_out <= `BUS_ADDR_RST;
		end else if (load_stb[0] && addr_ok) begin
			bus_addr_out <= a_r;
		end
	end

	// ==========================================
	// network address-assignment select
	always @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			auto_net_out <= `AUTO_NET_RST;
			manual_net_out <= ~`AUTO_NET_RST;
		end else if (load_stb[1]) begin
			auto_net_out <= n_r;
			manual_net_out <= ~n_r;
		end
	end

endmodule // host_port_arbiter
`default_nettype wire

/* File: verification/arb_monitor.sv */
// checker on the arbiter ports
// assumes bind onto host_port_arbiter
`timescale 1ns/100ps
`default_nettype none
module arb_monitor(input wire logic sys_clk_in, rst_n_in, cmd_valid_out, auto_net_out, manual_net_out,
	input wire logic [1:0] active_port_out, input wire logic [4:0] bus_addr_out);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_rng; bus_addr_out >= 5'h01 && bus_addr_out <= 5'h1e; endproperty
	a_rng: assert property (p_rng) else $error("address out of range");
	property p_nz; bus_addr_out != 5'h00; endproperty
	a_nz: assert property (p_nz) else $error("address zero");
	property p_rst6; $rose(rst_n_in) |-> bus_addr_out == 5'h01; endproperty
	a_rst6: assert property (p_rst6) else $error("address reset");
	property p_rst7; $rose(rst_n_in) |-> auto_net_out; endproperty
	a_rst7: assert property (p_rst7) else $error("flag reset");
	property p_man; manual_net_out == !auto_net_out; endproperty
	a_man: assert property (p_man) else $error("manual select");
	property p_hold; active_port_out != 2'h0 && $past(active_port_out) != 2'h0 |-> $stable(active_port_out); endproperty
	a_hold: assert property (p_hold) else $error("port switched");
	property p_fwd; cmd_valid_out |-> active_port_out != 2'h0 ##1 !cmd_valid_out; endproperty
	a_fwd: assert property (p_fwd) else $error("forward");
	property p_claim; $changed(active_port_out) && active_port_out != 2'h0 |-> cmd_valid_out; endproperty
	a_claim: assert property (p_claim) else $error("claim");
endmodule // arb_monitor
bind host_port_arbiter arb_monitor u_mon(.*);
`default_nettype wire

/* File: verification/host_link.sv */
// host side byte sender
// assumes a one-cycle go request
`timescale 1ns/100ps
`default_nettype none
module host_link(input wire logic clk_in, go_in, input wire logic [7:0] byte_in,
	output logic valid_out, output logic [7:0] data_out);
	logic [2:0] n_r = 3'h0;
	initial data_out = 8'h00;
	always @(posedge clk_in) begin
		n_r <= go_in ? 3'h1 : (n_r != 3'h0 ? n_r + 3'h1 : 3'h0);
		// idle data toggles so a stale byte never passes
		data_out <= go_in ? byte_in : (n_r == 3'h0 ? ~data_out : data_out);
		valid_out <= n_r >= 3'h3;
	end
endmodule // host_link
`default_nettype wire

/* File: verification/host_port_arbiter_test.sv */
// self-checking bench for the arbiter
// assumes idle limit shortened to 50
`timescale 1ns/100ps
`default_nettype none
module host_port_arbiter_test;
	logic sys_clk_in = 0, rst_n_in = 0, sg = 0, mg = 0, al = 0, nl = 0, nv = 1;
	logic [7:0] sb = 0, mb = 0;
	logic [4:0] av = 0, ea, a;
	wire logic sv, mv, cv, an, mn;
	wire logic [7:0] sd, md, cd;
	wire logic [1:0] ap;
	wire logic [4:0] ba;
	int bad_count = 0, checked = 0, seed = 321, k, n_cv = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (cv === 1'b1) n_cv <= n_cv + 1;
	host_link hs(.clk_in(sys_clk_in), .go_in(sg), .byte_in(sb), .valid_out(sv), .data_out(sd));
	host_link hm(.clk_in(sys_clk_in), .go_in(mg), .byte_in(mb), .valid_out(mv), .data_out(md));
	host_port_arbiter #(.IDLE_LIMIT(36'd50)) DUT(.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.serial_valid_in(sv), .serial_data_in(sd), .module_valid_in(mv), .module_data_in(md),
		.addr_load_in(al), .addr_value_in(av), .auto_net_load_in(nl), .auto_net_value_in(nv),
		.cmd_valid_out(cv), .cmd_data_out(cd), .active_port_out(ap), .bus_addr_out(ba),
		.auto_net_out(an), .manual_net_out(mn));
	function logic [4:0] nxt(logic [4:0] o, logic [4:0] v);
		return (v >= 5'h01 && v <= 5'h1e) ? v : o;
	endfunction
	task chk(string n, logic [7:0] e, logic [7:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task tick(int c);
		repeat (c) @(posedge sys_clk_in);
		#1;
	endtask
	task send(logic p, logic [7:0] b);
		if (p) {mb, mg} = {b, 1'b1}; else {sb, sg} = {b, 1'b1};
		tick(1);
		{mg, sg} = 2'b00;
		tick(16);
	endtask
	task ld(logic [4:0] v, logic f);
		{av, nv} = {v, f};
		tick(4);
		{al, nl} = 2'b11;
		tick(3);
		{al, nl} = 2'b00;
		tick(8);
	endtask
	task conclude;
		$display("checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		conclude;
	end
	initial begin
		tick(10);
		rst_n_in = 1;
		tick(1);
		chk("addr", 8'h01, ba);
		chk("auto", 8'h01, an);
		k = $random(seed);
		send(0, k[7:0]);
		chk("data", k[7:0], cd);
		send(1, 8'h5a);
		chk("data", k[7:0], cd);
		send(0, 8'ha5);
		tick(30);
		chk("port", 8'h01, ap);
		tick(30);
		chk("port", 8'h00, ap);
		send(1, 8'h3c);
		chk("port", 8'h02, ap);
		chk("pulses", 8'h03, n_cv[7:0]);
		$display("test ports done");
		ea = ba;
		for (k = 0; k < 5; k++) begin
			a = k < 2 ? 5'h1f * k[4:0] : $random(seed);
			ld(a, k[0]);
			ea = nxt(ea, a);
			chk("addr", {3'h0, ea}, ba);
			chk("manual", {7'h0, ~k[0]}, mn);
			chk("auto", {7'h0, k[0]}, an);
		end
		$display("test settings done");
		conclude;
	end
endmodule // host_port_arbiter_test
`default_nettype wire
